// *** timer_pair_pkg.sv ***
// Purpose: Shared constants and types for the dual timer/counter block.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes: Control and mode registers are eight bits wide in the low lane.
package timer_pair_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map.
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_LOW_ZERO = 8'h08;
    localparam logic [7:0] ADDR_HIGH_ZERO = 8'h0c;
    localparam logic [7:0] ADDR_LOW_ONE = 8'h10;
    localparam logic [7:0] ADDR_HIGH_ONE = 8'h14;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register fields.
    localparam int BIT_OVF_ONE = 7;
    localparam int BIT_RUN_ONE = 6;
    localparam int BIT_OVF_ZERO = 5;
    localparam int BIT_RUN_ZERO = 4;
    localparam int BIT_EXT_FLAG_ONE = 3;
    localparam int BIT_EXT_TYPE_ONE = 2;
    localparam int BIT_EXT_FLAG_ZERO = 1;
    localparam int BIT_EXT_TYPE_ZERO = 0;

    // Mode register fields, per nibble; unit one sits in the upper nibble.
    localparam int NIBBLE_ONE = 4;
    localparam int BIT_QUALIFY = 3;
    localparam int BIT_COUNTER_SELECT = 2;
    localparam int BIT_MODE_HIGH = 1;
    localparam int BIT_MODE_LOW = 0;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } count_mode_type;

    ////////////////////////////////////////////////////////////////////////////////
    // Machine cycle: six states of one CPU clock each.
    localparam int MACHINE_CLOCKS = 6;

    typedef enum logic [2:0] {
        ST_S1 = 3'h0,
        ST_S2 = 3'h1,
        ST_S3 = 3'h2,
        ST_S4 = 3'h3,
        ST_S5 = 3'h4,
        ST_S6 = 3'h5
    } machine_state_type;

    localparam logic [3:0] PIN_IDLE = 4'hf;

endpackage

// *** pin_sample_if.sv ***
// Purpose: Carries sampled pin levels and edges from the sampler to the core.
// Assumes: One strobe per machine cycle from the core.
// Notes: Edge and level fields hold from one sample to the next.
`timescale 1ns/100ps
interface pin_sample_if;
    logic sampleStb;
    logic fresh;
    logic [1:0] countFall;
    logic [1:0] irqLevel;
    logic [1:0] irqFall;

    modport producer(input sampleStb, output fresh, countFall, irqLevel, irqFall);
    modport consumer(output sampleStb, input fresh, countFall, irqLevel, irqFall);
endinterface

// *** pin_sampler.sv ***
// Purpose: Synchronises the count and interrupt pins and samples them per machine cycle.
// Assumes: sampleStb is a one-cycle pulse once per machine cycle.
// Notes: Bits 1:0 are the count pins, bits 3:2 the active-low interrupt pins.
`timescale 1ns/100ps
module pin_sampler (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pins
    input wire logic [1:0] countPin,
    input wire logic [1:0] irqPin_n,
    // Core side
    pin_sample_if.producer smp
);

    logic [3:0] syncA_r;
    logic [3:0] syncB_r;
    logic [3:0] sample_r;
    logic [3:0] prevSample_r;
    logic fresh_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle-high reset values keep the first sample from faking a falling edge.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_r <= timer_pair_pkg::PIN_IDLE;
            syncB_r <= timer_pair_pkg::PIN_IDLE;
            sample_r <= timer_pair_pkg::PIN_IDLE;
            prevSample_r <= timer_pair_pkg::PIN_IDLE;
            fresh_r <= 1'b0;
        end else begin
            syncA_r <= {irqPin_n, countPin};
            syncB_r <= syncA_r;
            fresh_r <= smp.sampleStb;
            if (smp.sampleStb) begin
                sample_r <= syncB_r;
                prevSample_r <= sample_r;
            end
        end
    end

    // A level shorter than one machine cycle may fall between two samples and be lost.
    assign smp.countFall = prevSample_r[1:0] & ~sample_r[1:0];
    assign smp.irqFall = prevSample_r[3:2] & ~sample_r[3:2];
    assign smp.irqLevel = sample_r[3:2];
    assign smp.fresh = fresh_r;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_FALL_DETECT: assert property (
        smp.sampleStb && sample_r[0] && !syncB_r[0] |=> smp.countFall[0] [*5])
        else $error("Falling count edge not reported after sample.");

    AST_FALL_ONLY_AT_SAMPLE: assert property (
        $rose(smp.countFall[0]) |-> $past(smp.sampleStb))
        else $error("Count edge appeared without a sample strobe.");

endmodule // pin_sampler

// *** timer_pair.sv ***
// Purpose: Two timer/counter units with shared control/flag and mode registers on APB.
// Assumes: core_clk is the CPU clock; a machine cycle is six core_clk periods.
// Notes: Registers answer with one wait state; unmapped addresses raise pslverr.
// Behaviour
// - Timer function increments once per machine cycle of six CPU clocks.
// - Counter function increments only on a falling edge of its count pin.
// - Count pin sampled once per machine cycle in S5; high then low counts.
// - Counted value appears in S3 of the cycle after detection.
// - Edge recognition spans two machine cycles, so at most clock over twelve.
// - Each unit picks timer or counter function by its own select bit.
// - Two mode bits per unit choose one of four modes.
// - Overflow sets the unit's overflow flag; vectoring to its interrupt clears it.
// - Counting runs while run bit is set and qualify off or pin high.
// - External interrupt events set their flags; servicing the interrupt clears them.
// - Type bits select falling-edge or low-level external interrupt triggering.
// - Mode 0 is a 13-bit counter; rollover to zero sets overflow.
// - Mode 0 is an 8-bit stage fed by a divide-by-32 prescaler.
// - Mode 0 uses high byte and low five bits; upper three untouched.
// - Setting the run bit leaves the count registers unchanged.
// - Mode 1 works like mode 0 but with all sixteen bits.
// - Each unit has its own qualify bit, run bit, flag and pin.
// - Mode 2 low byte counts, reloads from unchanged high byte on overflow.
// - Unit one in mode 3 holds its count as if stopped.
// - Unit zero mode 3: two 8-bit counters, high byte uses unit one's run and flag.
`timescale 1ns/100ps
module timer_pair (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic countInputZero,
    input wire logic countInputOne,
    input wire logic extIrqPinZero_n,
    input wire logic extIrqPinOne_n,
    // Interrupt controller side: {ovf one, ext one, ovf zero, ext zero}
    input wire logic [3:0] irqVectorAck,
    output logic [3:0] irqRequest
);

    pin_sample_if smp();

    timer_pair_pkg::machine_state_type state_r;
    timer_pair_pkg::machine_state_type stateNxt;
    logic [7:0] control_r;
    logic [7:0] controlNxt;
    logic [7:0] mode_r;
    logic [7:0] lowZero_r;
    logic [7:0] lowZeroNxt;
    logic [7:0] highZero_r;
    logic [7:0] highZeroNxt;
    logic [7:0] lowOne_r;
    logic [7:0] lowOneNxt;
    logic [7:0] highOne_r;
    logic [7:0] highOneNxt;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [7:0] readByte;
    logic addrHit;

    pin_sampler sampler (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .countPin({countInputOne, countInputZero}),
        .irqPin_n({extIrqPinOne_n, extIrqPinZero_n}),
        .smp(smp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Counting step shared by both units: returns {overflow, high, low}.
    function automatic logic [16:0] stepCount(input logic [1:0] mode, input logic [7:0] hi,
                                              input logic [7:0] lo);
        logic [5:0] prescale;
        logic [8:0] hiSum;
        logic [8:0] loSum;
        logic [16:0] full;
        logic [16:0] result;
        prescale = {1'b0, lo[4:0]} + 6'h01;
        hiSum = {1'b0, hi} + {8'h00, prescale[5]};
        loSum = {1'b0, lo} + 9'h001;
        full = {1'b0, hi, lo} + 17'h00001;
        case (mode)
            timer_pair_pkg::MODE_13BIT: begin
                // Five-bit prescaler carries into the 8-bit stage; bits 7:5 are left alone.
                result = {hiSum[8], hiSum[7:0], lo[7:5], prescale[4:0]};
            end
            timer_pair_pkg::MODE_16BIT: begin
                result = full;
            end
            timer_pair_pkg::MODE_RELOAD: begin
                result = {loSum[8], hi, loSum[8] ? hi : loSum[7:0]};
            end
            default: begin
                result = {loSum[8], hi, loSum[7:0]};
            end
        endcase
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Machine cycle sequencer.
    always_comb begin
        case (state_r)
            timer_pair_pkg::ST_S1: stateNxt = timer_pair_pkg::ST_S2;
            timer_pair_pkg::ST_S2: stateNxt = timer_pair_pkg::ST_S3;
            timer_pair_pkg::ST_S3: stateNxt = timer_pair_pkg::ST_S4;
            timer_pair_pkg::ST_S4: stateNxt = timer_pair_pkg::ST_S5;
            timer_pair_pkg::ST_S5: stateNxt = timer_pair_pkg::ST_S6;
            default: stateNxt = timer_pair_pkg::ST_S1;
        endcase
    end

    // Sampling in S5 and committing in the next S2 makes edge recognition take two cycles.
    wire commit = (state_r == timer_pair_pkg::ST_S2);
    assign smp.sampleStb = (state_r == timer_pair_pkg::ST_S5);

    ////////////////////////////////////////////////////////////////////////////////
    // Mode register decode.
    wire [1:0] modeZero = mode_r[timer_pair_pkg::BIT_MODE_HIGH:timer_pair_pkg::BIT_MODE_LOW];
    wire [1:0] modeOne = mode_r[timer_pair_pkg::NIBBLE_ONE + timer_pair_pkg::BIT_MODE_HIGH:
                                timer_pair_pkg::NIBBLE_ONE];
    wire qualifyZero = mode_r[timer_pair_pkg::BIT_QUALIFY];
    wire qualifyOne = mode_r[timer_pair_pkg::NIBBLE_ONE + timer_pair_pkg::BIT_QUALIFY];
    wire selectZero = mode_r[timer_pair_pkg::BIT_COUNTER_SELECT];
    wire selectOne = mode_r[timer_pair_pkg::NIBBLE_ONE + timer_pair_pkg::BIT_COUNTER_SELECT];
    wire splitZero = (modeZero == timer_pair_pkg::MODE_SPLIT);
    wire holdOne = (modeOne == timer_pair_pkg::MODE_SPLIT);
    wire runZero = control_r[timer_pair_pkg::BIT_RUN_ZERO];
    wire runOne = control_r[timer_pair_pkg::BIT_RUN_ONE];

    ////////////////////////////////////////////////////////////////////////////////
    // Count enables and events.
    wire enableZero = runZero && (!qualifyZero || smp.irqLevel[0]);
    wire enableOne = runOne && (!qualifyOne || smp.irqLevel[1]) && !holdOne;
    wire eventZero = selectZero ? smp.countFall[0] : 1'b1;
    wire eventOne = selectOne ? smp.countFall[1] : 1'b1;
    wire tickZero = commit && enableZero && eventZero;
    wire tickOne = commit && enableOne && eventOne;
    // In split mode the high byte of unit zero counts machine cycles on unit one's run bit.
    wire tickSplit = commit && splitZero && runOne;

    wire [16:0] stepZero = stepCount(modeZero, highZero_r, lowZero_r);
    wire [16:0] stepOne = stepCount(modeOne, highOne_r, lowOne_r);
    wire [8:0] splitSum = {1'b0, highZero_r} + 9'h001;
    wire ovfZero = tickZero && stepZero[16];
    // Unit one loses its flag to the split high byte and then counts silently.
    wire ovfOne = splitZero ? (tickSplit && splitSum[8]) : (tickOne && stepOne[16]);

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode; the answer comes one cycle after the access phase starts.
    wire apbAccess = psel && penable && pready_r;
    wire apbWrite = apbAccess && pwrite;
    wire wrControl = apbWrite && (paddr == timer_pair_pkg::ADDR_CONTROL);
    wire wrMode = apbWrite && (paddr == timer_pair_pkg::ADDR_MODE);
    wire wrLowZero = apbWrite && (paddr == timer_pair_pkg::ADDR_LOW_ZERO);
    wire wrHighZero = apbWrite && (paddr == timer_pair_pkg::ADDR_HIGH_ZERO);
    wire wrLowOne = apbWrite && (paddr == timer_pair_pkg::ADDR_LOW_ONE);
    wire wrHighOne = apbWrite && (paddr == timer_pair_pkg::ADDR_HIGH_ONE);

    always_comb begin
        readByte = 8'h00;
        addrHit = 1'b1;
        if (paddr == timer_pair_pkg::ADDR_CONTROL) begin
            readByte = control_r;
        end else if (paddr == timer_pair_pkg::ADDR_MODE) begin
            readByte = mode_r;
        end else if (paddr == timer_pair_pkg::ADDR_LOW_ZERO) begin
            readByte = lowZero_r;
        end else if (paddr == timer_pair_pkg::ADDR_HIGH_ZERO) begin
            readByte = highZero_r;
        end else if (paddr == timer_pair_pkg::ADDR_LOW_ONE) begin
            readByte = lowOne_r;
        end else if (paddr == timer_pair_pkg::ADDR_HIGH_ONE) begin
            readByte = highOne_r;
        end else begin
            addrHit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flag handling: software write, then vector clear, then hardware set on top.
    wire typeZero = control_r[timer_pair_pkg::BIT_EXT_TYPE_ZERO];
    wire typeOne = control_r[timer_pair_pkg::BIT_EXT_TYPE_ONE];
    wire extSetZero = smp.fresh && (typeZero ? smp.irqFall[0] : !smp.irqLevel[0]);
    wire extSetOne = smp.fresh && (typeOne ? smp.irqFall[1] : !smp.irqLevel[1]);
    wire [7:0] clearMask = {irqVectorAck[3], 1'b0, irqVectorAck[1], 1'b0,
                            irqVectorAck[2], 1'b0, irqVectorAck[0], 1'b0};
    wire [7:0] setMask = {ovfOne, 1'b0, ovfZero, 1'b0, extSetOne, 1'b0, extSetZero, 1'b0};
    wire [7:0] controlBase = wrControl ? pwdata[7:0] : control_r;

    // A set in the same cycle as a clear keeps the flag.
    assign controlNxt = (controlBase & ~clearMask) | setMask;

    // Writes to the control register never touch the counts.
    assign lowZeroNxt = wrLowZero ? pwdata[7:0] : (tickZero ? stepZero[7:0] : lowZero_r);
    assign highZeroNxt = wrHighZero ? pwdata[7:0] :
                         splitZero ? (tickSplit ? splitSum[7:0] : highZero_r) :
                         (tickZero ? stepZero[15:8] : highZero_r);
    assign lowOneNxt = wrLowOne ? pwdata[7:0] : (tickOne ? stepOne[7:0] : lowOne_r);
    assign highOneNxt = wrHighOne ? pwdata[7:0] : (tickOne ? stepOne[15:8] : highOne_r);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= timer_pair_pkg::ST_S1;
            control_r <= timer_pair_pkg::CONTROL_RESET;
            mode_r <= timer_pair_pkg::MODE_RESET;
        end else begin
            state_r <= stateNxt;
            control_r <= controlNxt;
            if (wrMode) begin
                mode_r <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowZero_r <= timer_pair_pkg::COUNT_RESET;
            highZero_r <= timer_pair_pkg::COUNT_RESET;
            lowOne_r <= timer_pair_pkg::COUNT_RESET;
            highOne_r <= timer_pair_pkg::COUNT_RESET;
        end else begin
            lowZero_r <= lowZeroNxt;
            highZero_r <= highZeroNxt;
            lowOne_r <= lowOneNxt;
            highOne_r <= highOneNxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= psel && penable && !pready_r;
            if (psel && penable && !pready_r) begin
                prdata_r <= {24'h000000, readByte};
                pslverr_r <= !addrHit;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irqRequest = {control_r[timer_pair_pkg::BIT_OVF_ONE],
                         control_r[timer_pair_pkg::BIT_EXT_FLAG_ONE],
                         control_r[timer_pair_pkg::BIT_OVF_ZERO],
                         control_r[timer_pair_pkg::BIT_EXT_FLAG_ZERO]};

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    wire noWriteZero = !wrLowZero && !wrHighZero;

    sequence machineCycle;
        !commit [*5] ##1 commit;
    endsequence

    sequence reloadedFromHigh;
        ##1 (lowZero_r == $past(highZero_r)) && $stable(highZero_r);
    endsequence

    AST_MACHINE_CYCLE: assert property (
        commit |=> machineCycle)
        else $error("Commit strobe not spaced by six clocks.");

    AST_UPDATE_AT_S2: assert property (
        $changed(lowZero_r) && !$past(wrLowZero) |-> $past(state_r) == timer_pair_pkg::ST_S2)
        else $error("Low byte of unit zero changed outside state S2.");

    AST_TIMER_STEP: assert property (
        commit && enableZero && !selectZero && modeZero == timer_pair_pkg::MODE_16BIT
        && noWriteZero |=> {highZero_r, lowZero_r} == $past({highZero_r, lowZero_r}) + 16'h0001)
        else $error("Sixteen-bit timer did not advance by one.");

    AST_OVF_SETS_FLAG: assert property (
        ovfZero |=> control_r[timer_pair_pkg::BIT_OVF_ZERO])
        else $error("Overflow of unit zero did not set its flag.");

    AST_RELOAD: assert property (
        tickZero && modeZero == timer_pair_pkg::MODE_RELOAD && lowZero_r == 8'hff
        && noWriteZero |-> reloadedFromHigh)
        else $error("Reload mode did not reload the low byte from the high byte.");

    AST_UNIT_ONE_HOLD: assert property (
        holdOne && !wrLowOne && !wrHighOne |=> $stable(lowOne_r) && $stable(highOne_r))
        else $error("Unit one counted in mode 3.");

    AST_GATE_BLOCKS: assert property (
        qualifyOne && !smp.irqLevel[1] && !wrLowOne |=> $stable(lowOne_r))
        else $error("Unit one counted with its qualify pin low.");

    AST_COUNTER_NEEDS_EDGE: assert property (
        commit && selectOne && !smp.countFall[1] && !wrLowOne |=> $stable(lowOne_r))
        else $error("Counter function advanced without a falling edge.");

    AST_MODE0_UPPER_BITS: assert property (
        modeZero == timer_pair_pkg::MODE_13BIT && !wrLowZero
        |=> lowZero_r[7:5] == $past(lowZero_r[7:5]))
        else $error("Mode 0 disturbed the upper three low-byte bits.");

endmodule // timer_pair

// *** ext_pin_model.sv ***
// Purpose: Drives the count and external interrupt pins of the timer pair.
// Assumes: Called from the bench just after a rising edge of core_clk.
// Notes: Every level stands two machine cycles, so none is missed by sampling.
`timescale 1ns/100ps
module ext_pin_model (
    // Clock
    input wire logic core_clk,
    // Pins
    output logic [1:0] countPin,
    output logic [1:0] irqPin_n
);
    initial begin
        countPin = 2'h3;
        irqPin_n = 2'h3;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One falling edge, then back high; both levels stand two machine cycles.
    task automatic fall(input int u);
        countPin[u] <= 1'b0;
        repeat (12) @(posedge core_clk);
        countPin[u] <= 1'b1;
        repeat (12) @(posedge core_clk);
    endtask
    task automatic setIrq(input int u, input logic lvl);
        irqPin_n[u] <= lvl;
        repeat (12) @(posedge core_clk);
    endtask
endmodule // ext_pin_model

// *** timer_pair_tb_top.sv ***
// Purpose: Self-checking bench for the timer pair over APB and its pins.
// Assumes: One wait state on APB; machine cycle of six clocks.
// Notes: Expected periods are counted in clocks from the end of the acknowledge to the next flag.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin numChecks++; if ((gt) !== (ex)) begin fails++; \
    $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module timer_pair_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] irqVectorAck = 4'h0;
    logic [3:0] irqRequest;
    logic [1:0] countPin;
    logic [1:0] irqPin_n;
    logic [31:0] rdat;
    logic err;
    int fails = 0;
    int numChecks = 0;
    int n;
    always #2.5 core_clk = ~core_clk;
    ext_pin_model pins (.core_clk(core_clk), .countPin(countPin), .irqPin_n(irqPin_n));
    timer_pair dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .countInputZero(countPin[0]), .countInputOne(countPin[1]),
        .extIrqPinZero_n(irqPin_n[0]), .extIrqPinOne_n(irqPin_n[1]),
        .irqVectorAck(irqVectorAck), .irqRequest(irqRequest));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d errors %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            fails++;
            conclude();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] ex, input logic ee);
        apb(1'b0, a, 32'h0);
        `CHK("read data", ex, rdat)
        `CHK("slave error", ee, err)
    endtask
    // Flag rise is seen one edge after the edge that sets it.
    task automatic waitFlag(input int b);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (irqRequest[b] !== 1'b1 && n < 400);
        if (n >= 400) begin
            fails++;
            conclude();
        end
    endtask
    task automatic ack(input logic [3:0] m);
        irqVectorAck <= m;
        @(posedge core_clk);
        irqVectorAck <= 4'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a < 6; a++) rdChk(8'(a * 4), 32'h0, 1'b0);
        rdChk(8'h18, 32'h0, 1'b1);
        apb(1'b1, timer_pair_pkg::ADDR_LOW_ZERO, 32'hff);
        apb(1'b1, timer_pair_pkg::ADDR_HIGH_ZERO, 32'hff);
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h10);
        waitFlag(1);
        `CHK("first tick", 1'b1, n <= 13)
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h00);
        rdChk(timer_pair_pkg::ADDR_LOW_ZERO, 32'he0, 1'b0);
        rdChk(timer_pair_pkg::ADDR_HIGH_ZERO, 32'h00, 1'b0);
        apb(1'b1, timer_pair_pkg::ADDR_MODE, 32'h02);
        apb(1'b1, timer_pair_pkg::ADDR_LOW_ZERO, 32'hfe);
        apb(1'b1, timer_pair_pkg::ADDR_HIGH_ZERO, 32'hfe);
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h10);
        waitFlag(1);
        ack(4'h2);
        waitFlag(1);
        `CHK("reload period", 11, n)
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h00);
        rdChk(timer_pair_pkg::ADDR_HIGH_ZERO, 32'hfe, 1'b0);
        apb(1'b1, timer_pair_pkg::ADDR_MODE, 32'hd0);
        apb(1'b1, timer_pair_pkg::ADDR_LOW_ONE, 32'hfe);
        apb(1'b1, timer_pair_pkg::ADDR_HIGH_ONE, 32'hff);
        pins.setIrq(1, 1'b0);
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h40);
        pins.fall(1);
        pins.fall(1);
        `CHK("gated count", 1'b0, irqRequest[3])
        `CHK("level flag one", 1'b1, irqRequest[2])
        pins.setIrq(1, 1'b1);
        pins.fall(1);
        `CHK("one edge", 1'b0, irqRequest[3])
        pins.fall(1);
        `CHK("two edges", 1'b1, irqRequest[3])
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h01);
        ack(4'hf);
        pins.setIrq(0, 1'b0);
        pins.setIrq(0, 1'b1);
        `CHK("edge flag", 1'b1, irqRequest[0])
        ack(4'h1);
        repeat (12) @(posedge core_clk);
        `CHK("edge flag ack", 1'b0, irqRequest[0])
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h00);
        pins.setIrq(0, 1'b0);
        ack(4'h1);
        repeat (12) @(posedge core_clk);
        `CHK("level flag", 1'b1, irqRequest[0])
        // Unit zero as a 16-bit timer while unit one sits in its holding mode.
        apb(1'b1, timer_pair_pkg::ADDR_MODE, 32'h31);
        apb(1'b1, timer_pair_pkg::ADDR_LOW_ZERO, 32'hfe);
        apb(1'b1, timer_pair_pkg::ADDR_HIGH_ZERO, 32'hff);
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h50);
        waitFlag(1);
        `CHK("wrap time", 1'b1, n <= 13)
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h00);
        rdChk(timer_pair_pkg::ADDR_LOW_ZERO, 32'h00, 1'b0);
        rdChk(timer_pair_pkg::ADDR_HIGH_ZERO, 32'h00, 1'b0);
        rdChk(timer_pair_pkg::ADDR_LOW_ONE, 32'h00, 1'b0);
        // Split unit zero: its high byte runs on unit one's run bit and flag.
        apb(1'b1, timer_pair_pkg::ADDR_MODE, 32'h03);
        apb(1'b1, timer_pair_pkg::ADDR_HIGH_ZERO, 32'hff);
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h40);
        waitFlag(3);
        `CHK("split flag", 1'b1, n <= 7)
        apb(1'b1, timer_pair_pkg::ADDR_CONTROL, 32'h00);
        rdChk(timer_pair_pkg::ADDR_HIGH_ZERO, 32'h00, 1'b0);
        rdChk(timer_pair_pkg::ADDR_LOW_ZERO, 32'h00, 1'b0);
        conclude();
    end
endmodule // timer_pair_tb_top
